// [logic/cfs_map.svh]
// How it works
// - Buck peak regulation 20 us sets flag
// - No buck limit flag during start or ramp
// - Boost peak regulation 64 us sets flag
// - Buck under 350 mV at 1 ms: off
// - Buck feedback low 1 ms in run: off
// - Boost below input 1 ms: off
// - Boost at 2.5 V stops switching at once
// - Buck fault sets short, summary, clears running
// - Boost fault sets short, summary, clears running
// - Short flag write-one clear restarts enabled converter
// - Disabled converter high impedance, optional discharge
// - Overvoltage kills all, outputs low, flag, irq
// - Overvoltage clear ignored while present; live bit
// - No enable during overvoltage or its pending flag
// - Overtemperature kills all, flag, irq, standby
// - Overtemperature clear ignored while hot; live bit
// - No enable while hot or flag pending
// - Thermal warning sets flag, irq, live bit
// - Warning mask one keeps irq line quiet
// - Undervoltage: all off, defaults, reset flag
// - Memory single error flagged, double error flagged
// - Negative current clamp raises no interrupt
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

// Register word offsets, decoded from address bits 3:2
`define CFS_OFS_CTRL    2'h0
`define CFS_OFS_MASK    2'h1
`define CFS_OFS_FLAGS   2'h2
`define CFS_OFS_STATUS  2'h3

// Reset values
`define CFS_CTRL_RST    15'h0000
`define CFS_MASK_RST    14'h0000
`define CFS_FLAGS_RST   14'h0800

// Timing in ns and conversion, least times round up
`define CFS_CLK_PERIOD_NS    40
`define CFS_T_BUCK_ILIM_NS   20000
`define CFS_T_BOOST_PEAK_LIMIT_SEL_NS  64000
`define CFS_T_OVLD_NS        1000000
`define CFS_CYC(ns) (((ns) + `CFS_CLK_PERIOD_NS - 1) / `CFS_CLK_PERIOD_NS)

`endif

// [logic/cfs_pkg.sv]
package cfs_pkg;

    // Control register layout, msb first
    typedef struct packed {
        logic [1:0]      boost_peak_limit_sel;  // Boost current limit code
        logic [1:0][2:0] buck_peak_limit_sel;   // Buck current limit codes
        logic            thermal_warning_threshold_sel;
        logic            boost_discharge_enable;
        logic [1:0]      buck_discharge_enable;
        logic            boost_en;
        logic [1:0]      buck_en;
    } cfs_ctrl_s;

    // Sticky flags, same layout in the mask register
    typedef struct packed {
        logic       double_error_flag;
        logic       single_error_flag;
        logic       reset_flag;
        logic       thermal_warning_flag;
        logic       thermal_shutdown_flag;
        logic       overvoltage_flag;
        logic       boost_summary_flag;
        logic       buck_summary_flag;
        logic       boost_short_flag;
        logic [1:0] buck_short_flag;
        logic       boost_curlim_flag;
        logic [1:0] buck_curlim_flag;
    } cfs_flags_s;

    // Live status bits
    typedef struct packed {
        logic       standby;
        logic       thermal_warning_live;
        logic       thermal_shutdown_live;
        logic       overvoltage_live;
        logic       boost_running_status;
        logic [1:0] buck_running_status;
        logic       boost_curlim_live;
        logic [1:0] buck_curlim_live;
    } cfs_status_s;

    // Synchronised comparator pins
    typedef struct packed {
        logic       main_supply_low;
        logic [1:0] die_warn_cmp;
        logic       die_over_sd;
        logic       vin_over;
        logic       boost_below_2v5;
        logic       boost_below_vin;
        logic       boost_peak_reg;
        logic [1:0] buck_fb_low;
        logic [1:0] buck_peak_reg;
    } cfs_pins_s;

endpackage : cfs_pkg

// [logic/cfs_top.sv]
`timescale 1ns/10ps
`include "cfs_map.svh"

module cfs_top #(
    parameter int P_OVLD_CYC = `CFS_CYC(`CFS_T_OVLD_NS)  // Overload window in cycles
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Analog comparator pins, asynchronous
    input  wire logic [1:0]  i_buck_peak_reg,
    input  wire logic [1:0]  i_buck_fb_low,
    input  wire logic        i_boost_peak_reg,
    input  wire logic        i_boost_below_vin,
    input  wire logic        i_boost_below_2v5,
    input  wire logic        i_vin_over,
    input  wire logic        i_die_over_sd,
    input  wire logic [1:0]  i_die_warn_cmp,
    input  wire logic        i_main_supply_low,
    // Same-clock inputs from sequencer and memory loader
    input  wire logic [1:0]  i_buck_ramp,
    input  wire logic        i_otp_single_err,
    input  wire logic        i_otp_double_err,
    // Converter control
    output logic [1:0]       o_buck_run,
    output logic [1:0]       o_buck_hiz,
    output logic [1:0]       o_buck_discharge,
    output logic             o_boost_run,
    output logic             o_boost_hiz,
    output logic             o_boost_discharge,
    output logic             o_boost_stop_sw,
    output logic [5:0]       o_buck_peak_limit_sel,
    output logic [1:0]       o_boost_peak_limit_sel,
    // Device state
    output logic             o_gpo_force_low,
    output logic             o_standby,
    output logic             o_irq_line_n
);

    // Cycle counts derived from times
    localparam int BUCK_ILIM_CYC  = `CFS_CYC(`CFS_T_BUCK_ILIM_NS);
    localparam int BOOST_PEAK_LIMIT_SEL_CYC = `CFS_CYC(`CFS_T_BOOST_PEAK_LIMIT_SEL_NS);
    localparam int OW = $clog2(P_OVLD_CYC + 1);      // Overload counter width
    localparam int IW = $clog2(BOOST_PEAK_LIMIT_SEL_CYC + 2);  // Limit counter width
    localparam logic [OW-1:0] OVLD_LAST = OW'(P_OVLD_CYC - 1);
    localparam logic [IW-1:0] BUCK_ILAST = IW'(BUCK_ILIM_CYC - 1);
    localparam logic [IW-1:0] BOOST_ILAST = IW'(BOOST_PEAK_LIMIT_SEL_CYC - 1);

    // Refuse a window the counters cannot time
    if (P_OVLD_CYC < 2) begin : g_bad_ovld
        $error("P_OVLD_CYC must be at least 2");
    end

    // Synchroniser stages
    cfs_pkg::cfs_pins_s pin_meta_q;   // First stage, read only by second
    cfs_pkg::cfs_pins_s pin_q;        // Second stage, safe to use
    logic               uvlo_prev_q;  // Undervoltage of previous cycle

    // Registers
    cfs_pkg::cfs_ctrl_s   ctrl_q;
    cfs_pkg::cfs_flags_s  mask_q;
    cfs_pkg::cfs_flags_s  flags_q;
    cfs_pkg::cfs_flags_s  flags_d;
    cfs_pkg::cfs_flags_s  flag_set;   // Hardware set terms
    cfs_pkg::cfs_flags_s  flag_clr;   // Software clear terms
    cfs_pkg::cfs_status_s status;

    // Bus slave state
    logic [31:0] rdata_q;
    logic        wait_q;
    logic [31:0] wmask;
    logic        bus_req;
    logic        wr_take;             // Write takes effect this edge
    logic [1:0]  reg_sel;
    logic        reg_hit;

    // Converter state
    logic [1:0]          buck_run_q;
    logic [1:0]          buck_start_q;   // In start-up window
    logic [1:0][OW-1:0]  buck_ovl_q;
    logic [1:0][IW-1:0]  buck_ilim_q;
    logic [1:0]          buck_ok;
    logic [1:0]          buck_fault;
    logic [1:0]          buck_ilim_hit;
    logic                boost_run_q;
    logic                boost_start_q;
    logic [OW-1:0]       boost_ovl_q;
    logic [IW-1:0]       boost_peak_limit_sel_q;
    logic                boost_ok;
    logic                boost_fault;
    logic                boost_peak_limit_sel_hit;
    logic                warn_prev_q;
    logic                warn_live;
    logic                block_all;      // Global enable veto
    logic                uvlo;

    // Two-flop synchroniser for every comparator pin
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_meta_q <= '0;
            pin_q      <= '0;
        end else begin
            pin_meta_q <= {i_main_supply_low, i_die_warn_cmp, i_die_over_sd, i_vin_over,
                           i_boost_below_2v5, i_boost_below_vin, i_boost_peak_reg,
                           i_buck_fb_low, i_buck_peak_reg};
            pin_q      <= pin_meta_q;
        end
    end

    assign uvlo      = pin_q.main_supply_low;
    // Warning comparator chosen by threshold select
    assign warn_live = ctrl_q.thermal_warning_threshold_sel ? pin_q.die_warn_cmp[1]
                                                            : pin_q.die_warn_cmp[0];
    // Enable veto from live faults or pending flags
    assign block_all = uvlo
                     | pin_q.vin_over | flags_q.overvoltage_flag
                     | pin_q.die_over_sd | flags_q.thermal_shutdown_flag;

    // Bus decode and byte lanes
    assign bus_req = i_avs_read | i_avs_write;
    assign reg_sel = i_avs_address[3:2];
    assign reg_hit = (i_avs_address[1:0] == 2'h0);
    assign wr_take = i_avs_write & ~wait_q & reg_hit;
    assign wmask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // Waitrequest: one wait cycle, then the answer cycle
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_q <= 1'b1;
        end else if (bus_req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data captured while waitrequest is high
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (i_avs_read && wait_q) begin
            if (!reg_hit) begin
                rdata_q <= '0;                  // Unaligned reads as zero
            end else begin
                case (reg_sel)
                    `CFS_OFS_CTRL:   rdata_q <= 32'(ctrl_q);
                    `CFS_OFS_MASK:   rdata_q <= 32'(mask_q);
                    `CFS_OFS_FLAGS:  rdata_q <= 32'(flags_q);
                    `CFS_OFS_STATUS: rdata_q <= 32'(status);
                    default:         rdata_q <= '0;
                endcase
            end
        end
    end

    // Control register, back to defaults in undervoltage
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q <= `CFS_CTRL_RST;
        end else if (uvlo) begin
            ctrl_q <= `CFS_CTRL_RST;
        end else if (wr_take && reg_sel == `CFS_OFS_CTRL) begin
            ctrl_q <= 15'((32'(ctrl_q) & ~wmask) | (i_avs_writedata & wmask));
        end
    end

    // Mask register
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_q <= `CFS_MASK_RST;
        end else if (uvlo) begin
            mask_q <= `CFS_MASK_RST;
        end else if (wr_take && reg_sel == `CFS_OFS_MASK) begin
            mask_q <= 14'((32'(mask_q) & ~wmask) | (i_avs_writedata & wmask));
        end
    end

    // Buck supervision, one copy per converter
    for (genvar b = 0; b < 2; b++) begin : g_buck
        // Allowed to run: enabled, no veto, no pending short
        assign buck_ok[b] = ctrl_q.buck_en[b] & ~block_all
                          & ~flags_q.buck_short_flag[b];
        // Low output at end of start-up, or low for the whole window after
        assign buck_fault[b] = buck_run_q[b] & pin_q.buck_fb_low[b]
                             & (buck_ovl_q[b] == OVLD_LAST);
        // Limit timing ends exactly once per episode
        assign buck_ilim_hit[b] = buck_run_q[b] & pin_q.buck_peak_reg[b]
                                & (buck_ilim_q[b] == BUCK_ILAST);

        // Running state
        always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
                buck_run_q[b] <= 1'b0;
            end else begin
                buck_run_q[b] <= buck_ok[b] & ~buck_fault[b];
            end
        end

        // Start-up window and overload counter
        always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
                buck_start_q[b] <= 1'b1;
                buck_ovl_q[b]   <= '0;
            end else if (!buck_run_q[b]) begin
                buck_start_q[b] <= 1'b1;      // Restart arms a new start-up
                buck_ovl_q[b]   <= '0;
            end else if (buck_start_q[b]) begin
                if (buck_ovl_q[b] == OVLD_LAST) begin
                    buck_start_q[b] <= 1'b0;
                    buck_ovl_q[b]   <= '0;
                end else begin
                    buck_ovl_q[b] <= buck_ovl_q[b] + 1'b1;
                end
            end else if (pin_q.buck_fb_low[b]) begin
                if (buck_ovl_q[b] != OVLD_LAST) begin
                    buck_ovl_q[b] <= buck_ovl_q[b] + 1'b1;
                end
            end else begin
                buck_ovl_q[b] <= '0;          // Low level must be continuous
            end
        end

        // Peak regulation persistence, quiet during start or ramp
        always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
                buck_ilim_q[b] <= '0;
            end else if (!buck_run_q[b] || buck_start_q[b] || i_buck_ramp[b]
                         || !pin_q.buck_peak_reg[b]) begin
                buck_ilim_q[b] <= '0;
            end else if (buck_ilim_q[b] != BUCK_ILAST + 1'b1) begin
                buck_ilim_q[b] <= buck_ilim_q[b] + 1'b1;
            end
        end
    end

    // Boost allowed to run
    assign boost_ok = ctrl_q.boost_en & ~block_all & ~flags_q.boost_short_flag;
    // Below input at end of start-up, or for a whole window after
    assign boost_fault = boost_run_q & pin_q.boost_below_vin
                       & (boost_ovl_q == OVLD_LAST);
    assign boost_peak_limit_sel_hit = boost_run_q & pin_q.boost_peak_reg
                          & (boost_peak_limit_sel_q == BOOST_ILAST);

    // Boost running state
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            boost_run_q <= 1'b0;
        end else begin
            boost_run_q <= boost_ok & ~boost_fault;
        end
    end

    // Boost start-up window and overload counter
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            boost_start_q <= 1'b1;
            boost_ovl_q   <= '0;
        end else if (!boost_run_q) begin
            boost_start_q <= 1'b1;
            boost_ovl_q   <= '0;
        end else if (boost_start_q) begin
            if (boost_ovl_q == OVLD_LAST) begin
                boost_start_q <= 1'b0;
                boost_ovl_q   <= '0;
            end else begin
                boost_ovl_q <= boost_ovl_q + 1'b1;
            end
        end else if (pin_q.boost_below_vin) begin
            if (boost_ovl_q != OVLD_LAST) begin
                boost_ovl_q <= boost_ovl_q + 1'b1;
            end
        end else begin
            boost_ovl_q <= '0;
        end
    end

    // Boost peak regulation persistence
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            boost_peak_limit_sel_q <= '0;
        end else if (!boost_run_q || !pin_q.boost_peak_reg) begin
            boost_peak_limit_sel_q <= '0;
        end else if (boost_peak_limit_sel_q != BOOST_ILAST + 1'b1) begin
            boost_peak_limit_sel_q <= boost_peak_limit_sel_q + 1'b1;
        end
    end

    // Previous warning and supply levels for edge detection
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            warn_prev_q <= 1'b0;
            uvlo_prev_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_live;
            uvlo_prev_q <= uvlo;
        end
    end

    // Hardware set terms; negative current clamp has no flag at all
    always_comb begin
        flag_set                       = '0;
        flag_set.buck_curlim_flag      = buck_ilim_hit;
        flag_set.boost_curlim_flag     = boost_peak_limit_sel_hit;
        flag_set.buck_short_flag       = buck_fault;
        flag_set.buck_summary_flag     = |buck_fault;
        flag_set.boost_short_flag      = boost_fault;
        flag_set.boost_summary_flag    = boost_fault;
        flag_set.overvoltage_flag      = pin_q.vin_over;
        flag_set.thermal_shutdown_flag = pin_q.die_over_sd;
        flag_set.thermal_warning_flag  = warn_live & ~warn_prev_q;
        flag_set.reset_flag            = uvlo_prev_q & ~uvlo
                                       & ~mask_q.reset_flag;
        flag_set.single_error_flag     = i_otp_single_err;
        flag_set.double_error_flag     = i_otp_double_err;
    end

    // Write-one clear terms, only at the accepting edge
    always_comb begin
        flag_clr = '0;
        if (wr_take && reg_sel == `CFS_OFS_FLAGS) begin
            flag_clr = 14'(i_avs_writedata & wmask);
        end
    end

    // Set wins over clear; a live fault keeps its flag set
    assign flags_d = (flags_q & ~flag_clr) | flag_set;

    // Flag register, wiped in undervoltage including the reset flag
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_q <= `CFS_FLAGS_RST;
        end else if (uvlo) begin
            flags_q <= `CFS_FLAGS_RST & ~`CFS_MASK_RST & 14'h0000;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Live status view
    always_comb begin
        status                       = '0;
        status.buck_curlim_live      = pin_q.buck_peak_reg & buck_run_q;
        status.boost_curlim_live     = pin_q.boost_peak_reg & boost_run_q;
        status.buck_running_status   = buck_run_q;
        status.boost_running_status  = boost_run_q;
        status.overvoltage_live      = pin_q.vin_over;
        status.thermal_shutdown_live = pin_q.die_over_sd;
        status.thermal_warning_live  = warn_live;
        status.standby               = ~(|buck_run_q | boost_run_q);
    end

    // Registered pin outputs
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_buck_run             <= '0;
            o_buck_hiz             <= 2'h3;
            o_buck_discharge       <= '0;
            o_boost_run            <= 1'b0;
            o_boost_hiz            <= 1'b1;
            o_boost_discharge      <= 1'b0;
            o_boost_stop_sw        <= 1'b0;
            o_buck_peak_limit_sel  <= '0;
            o_boost_peak_limit_sel <= '0;
            o_gpo_force_low        <= 1'b0;
            o_standby              <= 1'b1;
            o_irq_line_n           <= 1'b1;
        end else begin
            o_buck_run        <= buck_run_q;
            o_buck_hiz        <= ~buck_run_q;
            o_buck_discharge  <= ~buck_run_q & ctrl_q.buck_discharge_enable;
            o_boost_run       <= boost_run_q;
            o_boost_hiz       <= ~boost_run_q;
            o_boost_discharge <= ~boost_run_q & ctrl_q.boost_discharge_enable;
            o_boost_stop_sw   <= boost_run_q & pin_q.boost_below_2v5;
            o_buck_peak_limit_sel  <= ctrl_q.buck_peak_limit_sel;
            o_boost_peak_limit_sel <= ctrl_q.boost_peak_limit_sel;
            o_gpo_force_low   <= pin_q.vin_over | flags_q.overvoltage_flag;
            o_standby         <= status.standby;
            o_irq_line_n      <= ~|(flags_q & ~mask_q);
        end
    end

    // Bus outputs straight from flops
    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = wait_q;

endmodule : cfs_top

// [sim/cfs_chk.sv]
`timescale 1ns/10ps
module cfs_chk (
    // Clock, reset, comparators
    input wire logic       i_ref_clk,
    input wire logic       i_reset,
    input wire logic       i_vin_over,
    input wire logic       i_die_over_sd,
    input wire logic       i_main_supply_low,
    input wire logic       i_boost_below_2v5,
    // Converter and device outputs
    input wire logic [1:0] o_buck_run,
    input wire logic [1:0] o_buck_hiz,
    input wire logic [1:0] o_buck_discharge,
    input wire logic       o_boost_run,
    input wire logic       o_boost_hiz,
    input wire logic       o_boost_stop_sw,
    input wire logic       o_gpo_force_low,
    input wire logic       o_standby,
    input wire logic       o_irq_line_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    wire any_run = (|o_buck_run) || o_boost_run;  // Any converter switching
    buck_hiz_a: assert property (o_buck_hiz == ~o_buck_run)
        else $error("buck hiz and run disagree");
    boost_hiz_a: assert property (o_boost_hiz != o_boost_run)
        else $error("boost hiz and run disagree");
    discharge_off_a: assert property ((o_buck_discharge & ~o_buck_hiz) == 2'h0)
        else $error("discharge while switching");
    stop_sw_a: assert property ($rose(i_boost_below_2v5) && o_boost_run
        |-> ##[1:4] (o_boost_stop_sw || !o_boost_run)) else $error("boost kept switching");
    ov_gpo_a: assert property (i_vin_over |-> ##[1:5] o_gpo_force_low)
        else $error("outputs not forced low");
    ov_veto_a: assert property (o_gpo_force_low [*2] |-> !any_run)
        else $error("converter runs during overvoltage");
    tsd_off_a: assert property (i_die_over_sd |-> ##[1:6] (!any_run && o_standby))
        else $error("converter runs when hot");
    uvlo_off_a: assert property (i_main_supply_low |-> ##[1:6] !any_run)
        else $error("converter runs in undervoltage");
    cover property (o_boost_stop_sw);
    cover property ($fell(o_irq_line_n));
    cover property (o_gpo_force_low && o_buck_hiz[0]);
endmodule : cfs_chk
bind cfs_top cfs_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_vin_over(i_vin_over),
    .i_die_over_sd(i_die_over_sd), .i_main_supply_low(i_main_supply_low),
    .i_boost_below_2v5(i_boost_below_2v5), .o_buck_run(o_buck_run), .o_buck_hiz(o_buck_hiz),
    .o_buck_discharge(o_buck_discharge), .o_boost_run(o_boost_run), .o_boost_hiz(o_boost_hiz),
    .o_boost_stop_sw(o_boost_stop_sw), .o_gpo_force_low(o_gpo_force_low),
    .o_standby(o_standby), .o_irq_line_n(o_irq_line_n));

// [sim/cfs_plant.sv]
`timescale 1ns/10ps
module cfs_plant (
    // Clock, run state, injected short
    input wire logic       i_ref_clk,
    input wire logic [1:0] i_run,
    input wire logic [1:0] i_short,
    // Feedback comparator
    output logic [1:0]     o_fb_low
);
    logic [1:0][1:0] rise_q = '0;  // Cycles since run, saturates at 3
    // Output ramps for three cycles after the converter starts
    always_ff @(posedge i_ref_clk) begin
        for (int k = 0; k < 2; k++) begin
            rise_q[k] <= !i_run[k] ? 2'h0 : rise_q[k] + 2'(rise_q[k] != 2'h3);
        end
    end
    // Low while off, ramping or shorted
    always_comb begin
        for (int k = 0; k < 2; k++) o_fb_low[k] = i_short[k] || (rise_q[k] != 2'h3);
    end
endmodule : cfs_plant

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, low25 = 1'b0, uv = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdata;
    logic [1:0] pk = 2'h0, sh = 2'h0, hot = 2'h0, warn = 2'h0, brun, bhiz, bdis, fbl;
    logic wrq, force_low, irq_n, stopsw;
    logic [1:0] rmp = 2'h0, blim;
    logic [5:0] klim;
    int failures = 0, total_checks = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    cfs_plant plant (.i_ref_clk(clk), .i_run(brun), .i_short(sh), .o_fb_low(fbl));
    cfs_top #(.P_OVLD_CYC(20)) dut (.i_ref_clk(clk), .i_reset(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wrq), .i_buck_peak_reg(pk),
        .i_buck_fb_low(fbl), .i_boost_peak_reg(1'b0), .i_boost_below_vin(low25),
        .i_boost_below_2v5(low25), .i_vin_over(hot[0]), .i_die_over_sd(hot[1]),
        .i_die_warn_cmp(warn), .i_main_supply_low(uv), .i_buck_ramp(rmp),
        .i_otp_single_err(1'b0), .i_otp_double_err(1'b0), .o_buck_run(brun),
        .o_buck_hiz(bhiz), .o_buck_discharge(bdis), .o_boost_run(), .o_boost_hiz(),
        .o_boost_discharge(), .o_boost_stop_sw(stopsw), .o_buck_peak_limit_sel(klim),
        .o_boost_peak_limit_sel(blim), .o_gpo_force_low(force_low), .o_standby(),
        .o_irq_line_n(irq_n));
    task automatic complete_run;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wrq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rdata);
    endtask : rdc
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        wt(12);
        rst <= 1'b0;
        rdc("flags after reset", 4'h8, 32'h0000_0800);
        wt(2);
        chk("irq after reset", 32'h0000_0000, 32'(irq_n));
        bus(1'b1, 4'h8, 32'h0000_0800);
        bus(1'b1, 4'h0, 32'h0000_0009);
        wt(40);
        rdc("buck running", 4'hc, 32'h0000_0008);
        pk <= 2'h1;
        wt(520);
        rdc("curlim flag", 4'h8, 32'h0000_0001);
        rdc("curlim live", 4'hc, 32'h0000_0009);
        chk("curlim irq", 32'h0000_0000, 32'(irq_n));
        pk <= 2'h0;
        bus(1'b1, 4'h8, 32'h0000_0001);
        wt(4);
        chk("irq released", 32'h0000_0001, 32'(irq_n));
        rmp <= 2'h1;
        pk <= 2'h1;
        wt(520);
        rdc("ramp quiet", 4'h8, 32'h0000_0000);
        pk <= 2'h0;
        rmp <= 2'h0;
        sh <= 2'h1;
        wt(40);
        rdc("short flags", 4'h8, 32'h0000_0048);
        rdc("short status", 4'hc, 32'h0000_0200);
        chk("short hiz", 32'h0000_0001, 32'(bhiz[0]));
        chk("short discharge", 32'h0000_0001, 32'(bdis[0]));
        sh <= 2'h0;
        bus(1'b1, 4'h8, 32'h0000_0048);
        wt(40);
        rdc("restart", 4'hc, 32'h0000_0008);
        // Overvoltage, then overtemperature
        for (int i = 0; i < 2; i++) begin
            hot <= 2'(1 << i);
            wt(8);
            chk("fault run", 32'h0000_0000, 32'(brun));
            chk("gpo low", 32'(i == 0), 32'(force_low));
            bus(1'b1, 4'h8, 32'h0000_0300);
            rdc("flag kept", 4'h8, 32'h0000_0100 << i);
            rdc("fault live", 4'hc, 32'h0000_0200 | (32'h0000_0040 << i));
            hot <= 2'h0;
            wt(6);
            bus(1'b1, 4'h0, 32'h0000_0009);
            wt(40);
            rdc("enable refused", 4'hc, 32'h0000_0200);
            bus(1'b1, 4'h8, 32'h0000_0300);
            wt(40);
            rdc("fault cleared", 4'hc, 32'h0000_0008);
        end
        bus(1'b1, 4'h4, 32'h0000_0400);
        warn <= 2'h1;
        wt(8);
        rdc("warn flag", 4'h8, 32'h0000_0400);
        rdc("warn live", 4'hc, 32'h0000_0108);
        chk("warn masked", 32'h0000_0001, 32'(irq_n));
        warn <= 2'h0;
        bus(1'b1, 4'h4, 32'h0000_0000);
        wt(2);
        chk("warn unmasked", 32'h0000_0000, 32'(irq_n));
        bus(1'b1, 4'h8, 32'h0000_0400);
        rdc("unmapped", 4'h2, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0000_428d);
        wt(30);
        chk("limit sel", 32'h0000_0085, 32'({blim, klim}));
        low25 <= 1'b1;
        wt(8);
        chk("boost stop", 32'h0000_0001, 32'(stopsw));
        low25 <= 1'b0;
        wt(8);
        uv <= 1'b1;
        wt(8);
        chk("uvlo run", 32'h0000_0000, 32'(brun));
        uv <= 1'b0;
        wt(6);
        rdc("uvlo flags", 4'h8, 32'h0000_0800);
        rdc("uvlo ctrl", 4'h0, 32'h0000_0000);
        complete_run();
    end
endmodule : testbench
